// *** rtl/smid_decoder.sv ***
// The valid-and-take byte-stream port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module smid_decoder #(
    parameter int NREG = 16,
    parameter int NCH = 4,
    parameter int AW = 24
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // instruction byte stream
    input wire logic [7:0] CODE_BYTE,
    input wire logic CODE_VALID,
    output logic CODE_TAKE,
    output logic CYCLE_TICK,
    // ports
    input wire logic [7:0] PORT_A_IN,
    input wire logic [7:0] PORT_B_IN,
    input wire logic [7:0] PORT_C_IN,
    output logic [7:0] PORT_A_OUT,
    output logic [7:0] PORT_B_OUT,
    output logic [7:0] PORT_C_OUT,
    output logic [7:0] PORT_D_OUT,
    output logic [7:0] PORT_E_OUT,
    // sound and melody
    output logic [AW-1:0] SOUND_BEGIN_ADDR [2*NCH],
    output logic [AW-1:0] SOUND_FINAL_ADDR [2*NCH],
    output logic [AW-1:0] SONG_ADDR,
    output logic [7:0] TEMPO_CODE,
    output logic [5:0] VOLUME,
    output logic [4:0] CHANNEL_RATE [NCH],
    output logic [NCH-1:0] CHANNEL_PLAY,
    output logic [NCH-1:0] CHANNEL_GROUP_B,
    input wire logic [NCH-1:0] CHANNEL_DONE,
    // system
    input wire logic IRQ_EVENT,
    output logic IRQ_PENDING,
    output logic IRQ_ENABLED,
    output logic POWER_DOWN,
    output logic CARRY
);
    // one cycle of 64 clocks paces every byte fetch
    localparam int CW = $clog2(smid_pkg::CLKS_PER_CYCLE);
    logic [CW-1:0] div_q;
    logic tick;
    smid_pkg::smid_state_e state_q;
    logic [7:0] op_q, b1_q, b2_q, b3_q;
    logic [1:0] need;
    logic [7:0] regs_q [NREG];
    logic carry_q;
    logic [3:0] dest_register, source_register;
    logic [7:0] rd, rs;
    logic [8:0] sum;
    logic sum_wr, sum_cy;
    logic [2:0] channel_group_select;
    logic [15:0] sound_index;
    logic [AW-1:0] idx_addr;
    logic exec;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            div_q <= '0;
        end else if (state_q != smid_pkg::SMID_SLEEP) begin
            div_q <= div_q + CW'(1);
        end
    end
    assign tick = (div_q == CW'(smid_pkg::CLKS_PER_CYCLE - 1));
    assign CYCLE_TICK = tick;

    // operand byte count per opcode
    always_comb begin
        need = 2'd1;
        unique case (op_q)
            smid_pkg::OP_CLR_IRQ, smid_pkg::OP_IRQ_EN,
            smid_pkg::OP_PWR_DN: need = 2'd0;
            smid_pkg::OP_PLAY: need = 2'd2;
            smid_pkg::OP_SONG: need = 2'd3;
            default: begin
                if (op_q[7:4] == smid_pkg::OP_BEGIN_HI ||
                    op_q[7:4] == smid_pkg::OP_FINAL_HI) begin
                    need = 2'd3;
                end
            end
        endcase
    end

    assign CODE_TAKE = tick && CODE_VALID &&
        (state_q == smid_pkg::SMID_FETCH || state_q == smid_pkg::SMID_OPND1 ||
         state_q == smid_pkg::SMID_OPND2 || state_q == smid_pkg::SMID_OPND3);
    assign exec = (state_q == smid_pkg::SMID_EXEC) && tick;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= smid_pkg::SMID_FETCH;
            op_q <= 8'h00;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            b3_q <= 8'h00;
        end else begin
            unique case (state_q)
                smid_pkg::SMID_FETCH: if (CODE_TAKE) begin
                    op_q <= CODE_BYTE;
                    state_q <= smid_pkg::SMID_OPND1;
                end
                smid_pkg::SMID_OPND1: if (need == 2'd0) begin
                    state_q <= smid_pkg::SMID_EXEC;
                end else if (CODE_TAKE) begin
                    b1_q <= CODE_BYTE;
                    state_q <= (need == 2'd1) ? smid_pkg::SMID_EXEC
                                              : smid_pkg::SMID_OPND2;
                end
                smid_pkg::SMID_OPND2: if (CODE_TAKE) begin
                    b2_q <= CODE_BYTE;
                    state_q <= (need == 2'd2) ? smid_pkg::SMID_EXEC
                                              : smid_pkg::SMID_OPND3;
                end
                smid_pkg::SMID_OPND3: if (CODE_TAKE) begin
                    b3_q <= CODE_BYTE;
                    state_q <= smid_pkg::SMID_EXEC;
                end
                smid_pkg::SMID_EXEC: if (tick) begin
                    state_q <= (op_q == smid_pkg::OP_PWR_DN)
                        ? smid_pkg::SMID_SLEEP : smid_pkg::SMID_FETCH;
                end
                smid_pkg::SMID_SLEEP: if (IRQ_EVENT && IRQ_ENABLED) begin
                    state_q <= smid_pkg::SMID_FETCH;
                end
            endcase
        end
    end

    // operand fields
    assign dest_register = b1_q[7:4];
    assign source_register = b1_q[3:0];
    assign rd = regs_q[dest_register];
    assign rs = regs_q[source_register];
    assign channel_group_select = op_q[2:0];
    assign sound_index = {b1_q, b2_q};
    // three operand bytes form the address, first byte high
    assign idx_addr = AW'({sound_index, b3_q});

    // adder for the two-register family
    always_comb begin
        sum = 9'h000;
        sum_wr = 1'b0;
        sum_cy = 1'b0;
        unique case (op_q)
            smid_pkg::OP_ADD: begin
                sum = {1'b0, rd} + {1'b0, rs};
                sum_wr = 1'b1;
                sum_cy = 1'b1;
            end
            smid_pkg::OP_ADDC: begin
                sum = {1'b0, rd} + {1'b0, rs} + {8'h00, carry_q};
                sum_wr = 1'b1;
                sum_cy = 1'b1;
            end
            smid_pkg::OP_ADDK: begin
                sum = {1'b0, rd} + {1'b0, rs};
                sum_cy = 1'b1;
            end
            smid_pkg::OP_SUB: begin
                sum = {1'b0, rd} - {1'b0, rs};
                sum_wr = 1'b1;
                sum_cy = 1'b1;
            end
            smid_pkg::OP_SUBB: begin
                sum = {1'b0, rd} - {1'b0, rs} - {8'h00, carry_q};
                sum_wr = 1'b1;
                sum_cy = 1'b1;
            end
            smid_pkg::OP_SUBK: begin
                sum = {1'b0, rd} - {1'b0, rs};
                sum_cy = 1'b1;
            end
            smid_pkg::OP_AND: begin
                sum = {1'b0, rd & rs};
                sum_wr = 1'b1;
            end
            smid_pkg::OP_COPY: begin
                sum = {1'b0, rs};
                sum_wr = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // register bank: ALU and port input writes
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < NREG; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else if (exec) begin
            if (sum_wr) begin
                regs_q[dest_register] <= sum[7:0];
            end
            unique case (op_q)
                smid_pkg::OP_IN_A: regs_q[b1_q[3:0]] <= PORT_A_IN;
                smid_pkg::OP_IN_B: regs_q[b1_q[3:0]] <= PORT_B_IN;
                smid_pkg::OP_IN_C: regs_q[b1_q[3:0]] <= PORT_C_IN;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            carry_q <= 1'b0;
        end else if (exec && sum_cy) begin
            carry_q <= sum[8];
        end
    end
    assign CARRY = carry_q;

    // output ports
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            PORT_A_OUT <= 8'h00;
            PORT_B_OUT <= 8'h00;
            PORT_C_OUT <= 8'h00;
            PORT_D_OUT <= 8'h00;
            PORT_E_OUT <= 8'h00;
        end else if (exec && op_q >= smid_pkg::OP_OUT_A &&
                     op_q <= smid_pkg::OP_OUT_E) begin
            unique case (op_q[2:0])
                3'h0: PORT_A_OUT <= regs_q[b1_q[3:0]];
                3'h1: PORT_B_OUT <= regs_q[b1_q[3:0]];
                3'h2: PORT_C_OUT <= regs_q[b1_q[3:0]];
                3'h3: PORT_D_OUT <= regs_q[b1_q[3:0]];
                default: PORT_E_OUT <= regs_q[b1_q[3:0]];
            endcase
        end
    end

    // melody engine settings
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            SONG_ADDR <= '0;
            TEMPO_CODE <= 8'h00;
            VOLUME <= 6'h00;
        end else if (exec) begin
            unique case (op_q)
                smid_pkg::OP_SONG: SONG_ADDR <= idx_addr;
                smid_pkg::OP_TEMPO: TEMPO_CODE <= regs_q[b1_q[3:0]];
                smid_pkg::OP_GAIN: begin
                    // values above the top step saturate
                    VOLUME <= (regs_q[b1_q[3:0]] >
                               {2'b00, smid_pkg::VOLUME_MAX})
                        ? smid_pkg::VOLUME_MAX
                        : regs_q[b1_q[3:0]][5:0];
                end
                default: begin
                end
            endcase
        end
    end

    // per-group address registers, per-channel play state
    genvar g;
    generate
        for (g = 0; g < 2 * NCH; g++) begin : g_grp
            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    SOUND_BEGIN_ADDR[g] <= '0;
                    SOUND_FINAL_ADDR[g] <= '0;
                end else if (exec && channel_group_select == 3'(g)) begin
                    if (op_q[7:4] == smid_pkg::OP_BEGIN_HI) begin
                        SOUND_BEGIN_ADDR[g] <= idx_addr;
                    end
                    if (op_q[7:4] == smid_pkg::OP_FINAL_HI) begin
                        SOUND_FINAL_ADDR[g] <= idx_addr;
                    end
                end
            end
        end
        for (g = 0; g < NCH; g++) begin : g_ch
            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    CHANNEL_PLAY[g] <= 1'b0;
                    CHANNEL_GROUP_B[g] <= 1'b0;
                    CHANNEL_RATE[g] <= 5'h00;
                end else if (exec && op_q == smid_pkg::OP_PLAY &&
                             b1_q[2:1] == 2'(g)) begin
                    // one group flag per channel keeps A and B exclusive
                    CHANNEL_PLAY[g] <= 1'b1;
                    CHANNEL_GROUP_B[g] <= b1_q[0];
                    CHANNEL_RATE[g] <=
                        b2_q[4:0] & smid_pkg::RATE_MAX;
                end else if (CHANNEL_DONE[g]) begin
                    CHANNEL_PLAY[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // interrupt control; an arriving event beats the clear
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            IRQ_PENDING <= 1'b0;
        end else if (IRQ_EVENT) begin
            IRQ_PENDING <= 1'b1;
        end else if (exec && op_q == smid_pkg::OP_CLR_IRQ) begin
            IRQ_PENDING <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            IRQ_ENABLED <= 1'b0;
        end else if (exec && op_q == smid_pkg::OP_IRQ_EN) begin
            IRQ_ENABLED <= 1'b1;
        end
    end

    assign POWER_DOWN = (state_q == smid_pkg::SMID_SLEEP);
endmodule : smid_decoder

// *** rtl/smid_pkg.sv ***
// Function
// - D0 adds source into destination register; three cycles, two bytes.
// - D1 adds source plus carry into destination register.
// - D2 adds only to update carry; registers unchanged.
// - D4 subtracts source from destination into destination.
// - D5 subtracts source and carry from destination into destination.
// - D6 subtracts only to update carry; registers unchanged.
// - D8 ANDs both registers into destination.
// - D9 copies source into destination in three cycles.
// - 1n loads a sound start address into selected channel group.
// - 9n loads a sound end address into selected channel group.
// - CF loads the song start address into the melody engine.
// - CE starts playback on a group with rate code 0 to 31.
// - 8E takes a register value as melody tempo code.
// - 8F sets volume 0 to 63 from a register; 0 mutes.
// - 80, 81, 82 copy input port A, B, C into a register.
// - 88 to 8C write a register to output port A to E.
// - C8 clears the pending interrupt.
// - C9 enables interrupt acceptance.
// - CA shuts down; restart needs interrupts enabled beforehand.
// - four 4-bit ADPCM channels, each with its own 4 to 32 kHz rate.
// - each channel has groups A and B; never both playing.
// - one instruction cycle is 64 clock periods.
// - register operands select one of 16 eight-bit registers.
// - rate codes are defined at 2816 kHz; 19 is 16 kHz, 0 is 4 kHz.
package smid_pkg;
    localparam int CLKS_PER_CYCLE = 64;
    localparam logic [7:0] OP_ADD = 8'hD0;
    localparam logic [7:0] OP_ADDC = 8'hD1;
    localparam logic [7:0] OP_ADDK = 8'hD2;
    localparam logic [7:0] OP_SUB = 8'hD4;
    localparam logic [7:0] OP_SUBB = 8'hD5;
    localparam logic [7:0] OP_SUBK = 8'hD6;
    localparam logic [7:0] OP_AND = 8'hD8;
    localparam logic [7:0] OP_COPY = 8'hD9;
    localparam logic [3:0] OP_BEGIN_HI = 4'h1;
    localparam logic [3:0] OP_FINAL_HI = 4'h9;
    localparam logic [7:0] OP_SONG = 8'hCF;
    localparam logic [7:0] OP_PLAY = 8'hCE;
    localparam logic [7:0] OP_TEMPO = 8'h8E;
    localparam logic [7:0] OP_GAIN = 8'h8F;
    localparam logic [7:0] OP_IN_A = 8'h80;
    localparam logic [7:0] OP_IN_B = 8'h81;
    localparam logic [7:0] OP_IN_C = 8'h82;
    localparam logic [7:0] OP_OUT_A = 8'h88;
    localparam logic [7:0] OP_OUT_E = 8'h8C;
    localparam logic [7:0] OP_CLR_IRQ = 8'hC8;
    localparam logic [7:0] OP_IRQ_EN = 8'hC9;
    localparam logic [7:0] OP_PWR_DN = 8'hCA;
    localparam logic [5:0] VOLUME_MAX = 6'h3F;
    localparam logic [4:0] RATE_MAX = 5'h1F;
    typedef enum logic [2:0] {
        SMID_FETCH, SMID_OPND1, SMID_OPND2, SMID_OPND3, SMID_EXEC, SMID_SLEEP
    } smid_state_e;
endpackage : smid_pkg

// *** tb/smid_assertions.sv ***
`timescale 1ns/1ps
module smid_checker #(
    parameter int NCH = 4
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // stream
    input wire logic CODE_VALID,
    input wire logic CODE_TAKE,
    input wire logic CYCLE_TICK,
    // results
    input wire logic [7:0] PORT_A_OUT,
    input wire logic [7:0] TEMPO_CODE,
    input wire logic [5:0] VOLUME,
    input wire logic CARRY,
    input wire logic [NCH-1:0] CHANNEL_PLAY,
    input wire logic [NCH-1:0] CHANNEL_DONE,
    // system
    input wire logic IRQ_EVENT,
    input wire logic IRQ_PENDING,
    input wire logic IRQ_ENABLED,
    input wire logic POWER_DOWN
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);
    logic [6:0] gap_q;
    logic woke_q;
    // clocks since last tick; phase unknown after a wake
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            gap_q <= 7'h00;
        end else if (CYCLE_TICK || POWER_DOWN) begin
            gap_q <= 7'h00;
        end else begin
            gap_q <= gap_q + 7'h01;
        end
    end
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            woke_q <= 1'b0;
        end else if (POWER_DOWN || CYCLE_TICK) begin
            woke_q <= POWER_DOWN;
        end
    end
    sequence s_call; POWER_DOWN && IRQ_ENABLED && IRQ_EVENT; endsequence
    sequence s_awake; ##[1:3] !POWER_DOWN; endsequence
    property p_cycle;
        !woke_q && !POWER_DOWN |-> CYCLE_TICK == (gap_q == 7'h3F);
    endproperty
    property p_take; CODE_TAKE |-> CYCLE_TICK && CODE_VALID; endproperty
    property p_quiet; POWER_DOWN |-> !CYCLE_TICK && !CODE_TAKE; endproperty
    property p_stay; POWER_DOWN && !IRQ_ENABLED |=> POWER_DOWN; endproperty
    property p_wake; s_call |-> s_awake; endproperty
    property p_irq_set; IRQ_EVENT |=> IRQ_PENDING; endproperty
    property p_irq_clr; $fell(IRQ_PENDING) |-> $past(CYCLE_TICK); endproperty
    property p_out;
        $changed({PORT_A_OUT, TEMPO_CODE, VOLUME, CARRY}) |->
            $past(CYCLE_TICK);
    endproperty
    property p_done;
        |CHANNEL_DONE && !CYCLE_TICK |=>
            (CHANNEL_PLAY & $past(CHANNEL_DONE)) == '0;
    endproperty
    a_cycle: assert property (p_cycle) else $error("tick spacing");
    a_take: assert property (p_take) else $error("take off tick");
    a_quiet: assert property (p_quiet) else $error("busy asleep");
    a_stay: assert property (p_stay) else $error("woke unarmed");
    a_wake: assert property (p_wake) else $error("no wake");
    a_irq_set: assert property (p_irq_set) else $error("irq lost");
    a_irq_clr: assert property (p_irq_clr) else $error("irq clr");
    a_out: assert property (p_out) else $error("early update");
    a_done: assert property (p_done) else $error("still playing");
endmodule : smid_checker

bind smid_decoder smid_checker #(.NCH(NCH)) smid_checker_inst (
    .CLOCK, .RST_B, .CODE_VALID, .CODE_TAKE, .CYCLE_TICK, .PORT_A_OUT,
    .TEMPO_CODE, .VOLUME, .CARRY, .CHANNEL_PLAY, .CHANNEL_DONE,
    .IRQ_EVENT, .IRQ_PENDING, .IRQ_ENABLED, .POWER_DOWN
);

// *** tb/smid_code_mem.sv ***
`timescale 1ns/1ps
module smid_code_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // byte stream
    input wire logic take,
    output logic [7:0] code_byte,
    output logic code_valid
);
    logic [7:0] store_q [$];
    function automatic int level();
        return store_q.size();
    endfunction : level
    function automatic void push(input logic [7:0] b);
        store_q.push_back(b);
    endfunction : push
    // empty memory floats its data lines: toggle them
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            store_q.delete();
            code_valid <= 1'b0;
            code_byte <= 8'h5A;
        end else begin
            if (take && store_q.size() != 0) begin
                void'(store_q.pop_front());
            end
            code_valid <= store_q.size() != 0;
            code_byte <= store_q.size() != 0 ? store_q[0] : ~code_byte;
        end
    end
endmodule : smid_code_mem

// *** tb/sound_mcu_instruction_decoder_tb.sv ***
`timescale 1ns/1ps
module sound_mcu_instruction_decoder_tb;
    typedef struct {logic [7:0] op, a, b, r; logic c;} smid_row_s;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] pa_in = 8'h00, pb_in = 8'h00, pc_in = 8'h00;
    logic [3:0] done = 4'h0;
    logic irq_event = 1'b0;
    logic code_valid, code_take, tick, irq_pend, irq_en, pwr, carry;
    logic [7:0] code_byte, pa_out, pb_out, pc_out, pd_out, pe_out, tempo;
    logic [23:0] beg [8];
    logic [23:0] fin [8];
    logic [23:0] song;
    logic [5:0] volume;
    logic [4:0] rate [4];
    logic [3:0] play, grp_b;
    int miscompares = 0;
    int comparisons = 0;
    smid_row_s rows [8] = '{
        '{smid_pkg::OP_ADD, 8'hF0, 8'h20, 8'h10, 1'b1},
        '{smid_pkg::OP_ADDC, 8'h01, 8'h02, 8'h04, 1'b0},
        '{smid_pkg::OP_ADDK, 8'hFF, 8'h01, 8'hFF, 1'b1},
        '{smid_pkg::OP_SUBB, 8'h10, 8'h01, 8'h0E, 1'b0},
        '{smid_pkg::OP_SUBK, 8'h01, 8'h02, 8'h01, 1'b1},
        '{smid_pkg::OP_SUB, 8'h01, 8'h02, 8'hFF, 1'b1},
        '{smid_pkg::OP_AND, 8'h3C, 8'h0F, 8'h0C, 1'b1},
        '{smid_pkg::OP_COPY, 8'h00, 8'hA5, 8'hA5, 1'b1}
    };
    smid_code_mem smid_code_mem_inst (
        .clk(clk), .rst_b(rst_b), .take(code_take),
        .code_byte(code_byte), .code_valid(code_valid)
    );
    smid_decoder smid_decoder_inst (
        .CLOCK(clk), .RST_B(rst_b), .CODE_BYTE(code_byte),
        .CODE_VALID(code_valid), .CODE_TAKE(code_take), .CYCLE_TICK(tick),
        .PORT_A_IN(pa_in), .PORT_B_IN(pb_in), .PORT_C_IN(pc_in),
        .PORT_A_OUT(pa_out), .PORT_B_OUT(pb_out), .PORT_C_OUT(pc_out),
        .PORT_D_OUT(pd_out), .PORT_E_OUT(pe_out),
        .SOUND_BEGIN_ADDR(beg), .SOUND_FINAL_ADDR(fin), .SONG_ADDR(song),
        .TEMPO_CODE(tempo), .VOLUME(volume), .CHANNEL_RATE(rate),
        .CHANNEL_PLAY(play), .CHANNEL_GROUP_B(grp_b), .CHANNEL_DONE(done),
        .IRQ_EVENT(irq_event), .IRQ_PENDING(irq_pend),
        .IRQ_ENABLED(irq_en), .POWER_DOWN(pwr), .CARRY(carry)
    );
    always #25 clk = ~clk;
    task automatic test_done();
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic op2(input logic [7:0] op, input logic [7:0] b1);
        smid_code_mem_inst.push(op);
        smid_code_mem_inst.push(b1);
    endtask : op2
    task automatic op4(input logic [7:0] op, input logic [23:0] a);
        op2(op, a[23:16]);
        op2(a[15:8], a[7:0]);
    endtask : op4
    // drain the memory, then let the last instruction execute
    task automatic settle();
        int n;
        n = 0;
        while (smid_code_mem_inst.level() != 0 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 20000) begin
            miscompares++;
        end
        @(posedge tick);
        @(posedge clk);
        #1;
    endtask : settle
    task automatic pulse_irq();
        @(posedge clk);
        irq_event <= 1'b1;
        @(posedge clk);
        irq_event <= 1'b0;
        #1;
    endtask : pulse_irq
    initial begin
        #3_000_000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk(24'({pa_out, volume, play, carry, pwr, irq_en}), 24'h0);
        foreach (rows[i]) begin
            @(posedge clk);
            pa_in <= rows[i].a;
            pb_in <= rows[i].b;
            op2(smid_pkg::OP_IN_A, 8'h0F);
            op2(smid_pkg::OP_IN_B, 8'h00);
            op2(rows[i].op, 8'hF0);
            op2(smid_pkg::OP_OUT_A, 8'h0F);
            settle();
            chk(24'(pa_out), 24'(rows[i].r));
            chk(24'(carry), 24'(rows[i].c));
        end
        @(posedge clk);
        pc_in <= 8'h5A;
        pa_in <= 8'hEA;
        pb_in <= 8'h3F;
        op2(smid_pkg::OP_IN_C, 8'h01);
        for (int k = 1; k < 5; k++) begin
            op2(smid_pkg::OP_OUT_A + 8'(k), 8'h01);
        end
        op2(smid_pkg::OP_IN_A, 8'h02);
        op2(smid_pkg::OP_IN_B, 8'h03);
        op2(smid_pkg::OP_TEMPO, 8'h02);
        op2(smid_pkg::OP_GAIN, 8'h03);
        settle();
        chk(24'({pb_out, pc_out, pd_out}), 24'h5A5A5A);
        chk(24'({pe_out, pa_out}), 24'h5AA5);
        chk(24'({tempo, 2'b00, volume}), 24'hEA3F);
        op4({smid_pkg::OP_BEGIN_HI, 4'h7}, 24'hABCDEF);
        op4({smid_pkg::OP_FINAL_HI, 4'h2}, 24'h123456);
        op4(smid_pkg::OP_SONG, 24'h00FF01);
        op2(smid_pkg::OP_PLAY, 8'h07);
        smid_code_mem_inst.push(smid_pkg::RATE_MAX);
        op2(smid_pkg::OP_PLAY, 8'h01);
        smid_code_mem_inst.push(8'h13);
        settle();
        chk(beg[7], 24'hABCDEF);
        chk(fin[2], 24'h123456);
        chk(song, 24'h00FF01);
        chk(24'({rate[3], rate[0]}), 24'h3F3);
        chk(24'({play, grp_b}), 24'h99);
        op2(smid_pkg::OP_PLAY, 8'h06);
        smid_code_mem_inst.push(8'h05);
        settle();
        chk(24'({play, grp_b}), 24'h91);
        @(posedge clk);
        done <= 4'h8;
        @(posedge clk);
        done <= 4'h0;
        @(posedge clk);
        #1;
        chk(24'(play), 24'h1);
        smid_code_mem_inst.push(smid_pkg::OP_IRQ_EN);
        settle();
        pulse_irq();
        chk(24'({irq_en, irq_pend}), 24'h3);
        smid_code_mem_inst.push(smid_pkg::OP_CLR_IRQ);
        settle();
        chk(24'(irq_pend), 24'h0);
        smid_code_mem_inst.push(smid_pkg::OP_PWR_DN);
        settle();
        repeat (200) @(posedge clk);
        chk(24'(pwr), 24'h1);
        pulse_irq();
        repeat (3) @(posedge clk);
        #1;
        chk(24'(pwr), 24'h0);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        #1;
        chk(24'({pa_out, tempo, irq_en, carry}), 24'h0);
        @(posedge clk);
        rst_b <= 1'b1;
        // memory still sees reset low at this edge and empties itself
        @(posedge clk);
        #1;
        smid_code_mem_inst.push(smid_pkg::OP_PWR_DN);
        settle();
        pulse_irq();
        repeat (3) @(posedge clk);
        #1;
        chk(24'(pwr), 24'h1);
        test_done();
    end
endmodule : sound_mcu_instruction_decoder_tb
